// ### core/nvm_access_ctrl.sv
// Self-access controller for the data EEPROM and program flash
`timescale 1ns/1ps
`default_nettype none
`include "nvm_map.svh"
module nvm_access_ctrl
    import nvm_pkg::*;
#(
    parameter bit SMALL_PART   = 1'b0,
    parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire nvm_sfr_req_t sfrReq,
    input  wire logic         extRstReq,
    input  wire logic         wdtRstReq,
    output logic        [7:0] sfrRdData,
    output logic              nvmIrqReq,
    output logic              pumpOn,
    output logic              nvmBusy
);

    localparam int TW = $clog2(WRITE_CYCLES + 1);

    // ********************************************
    // Register state
    // ********************************************
    logic [7:0]  dataLo_q, dataLo_d, addrLo_q, addrLo_d, rdData_q, rdData_d;
    logic [5:0]  dataHi_q, dataHi_d;
    logic [4:0]  addrHi_q, addrHi_d, cnt_q, cnt_d;
    logic        space_q, space_d, rowErase_q, rowErase_d, abort_q, abort_d;
    logic        permit_q, permit_d, commit_q, commit_d, fetch_q, fetch_d;
    logic        doneFlag_q, doneFlag_d, irqEn_q, irqEn_d, opPgm_q, opPgm_d;
    logic        fetchPgm_q, fetchPgm_d, fetchHole_q, fetchHole_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic [13:0] blk_q [0:3];
    logic [13:0] blk_d [0:3];
    nvm_unlock_t ul_q, ul_d;
    nvm_op_t     st_q, st_d;

    // ********************************************
    // Decode and derived addresses
    // ********************************************
    logic        wrCtrl, wrKey, softRst, busy, startOk, fetchStart, opEnd, holeAddr;
    logic [12:0] pgmFull;
    logic [10:0] pgmAddr;
    logic        dWe, pWe;
    logic [10:0] pWrAddr;
    logic [13:0] pWrData, pRd;
    logic [7:0]  dWrData, dRd;
    logic [TW-1:0] tmrLoad;

    assign wrCtrl   = sfrReq.we && (sfrReq.addr == `NVM_OFS_CTRL);
    assign wrKey    = sfrReq.we && (sfrReq.addr == `NVM_OFS_KEY);
    assign softRst  = extRstReq || wdtRstReq;
    assign busy     = (st_q != OP_IDLE);
    assign tmrLoad  = TW'(WRITE_CYCLES - 1);
    assign holeAddr = SMALL_PART && addrLo_q[7];
    assign pgmFull  = {addrHi_q, addrLo_q};
    assign pgmAddr  = {pgmFull[10] & ~SMALL_PART, pgmFull[9:0]};
    // Commit only after the key pair, with writes allowed and nothing running
    assign startOk  = wrCtrl && sfrReq.wdata[`NVM_BIT_COMMIT] && (ul_q == UL_ARMED)
                      && permit_q && !busy && !softRst;
    assign fetchStart = wrCtrl && sfrReq.wdata[`NVM_BIT_FETCH] && !busy && !fetch_q
                        && !softRst;

    // ********************************************
    // Unlock tracker
    // ********************************************
    // Any other write on the bus breaks the sequence; a stray 55h restarts it
    always_comb begin
        ul_d = UL_IDLE;
        if (!sfrReq.we) begin
            ul_d = ul_q;
        end else if (wrKey && sfrReq.wdata == `NVM_KEY_SECOND && ul_q == UL_HALF) begin
            ul_d = UL_ARMED;
        end else if (wrKey && sfrReq.wdata == `NVM_KEY_FIRST) begin
            ul_d = UL_HALF;
        end
        if (softRst) begin
            ul_d = UL_IDLE;
        end
    end

    // ********************************************
    // Write and erase sequencer
    // ********************************************
    // Sequencer writes the arrays one word a cycle, then waits the timed interval
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        tmr_d    = tmr_q;
        opPgm_d  = opPgm_q;
        commit_d = commit_q;
        blk_d    = blk_q;
        opEnd    = 1'b0;
        dWe      = 1'b0;
        pWe      = 1'b0;
        dWrData  = dataLo_q;
        pWrAddr  = {pgmAddr[10:2], cnt_q[1:0]};
        pWrData  = blk_q[cnt_q[1:0]];
        unique case (st_q)
            OP_IDLE: begin
                if (startOk) begin
                    opPgm_d  = space_q;
                    commit_d = 1'b1;
                    cnt_d    = 5'h00;
                    if (!space_q || rowErase_q) begin
                        st_d = OP_WIPE;
                    end else begin
                        blk_d[addrLo_q[1:0]] = {dataHi_q, dataLo_q};
                        if (addrLo_q[1:0] == 2'h3) begin
                            st_d = OP_FILL;
                        end else begin
                            commit_d = 1'b0;
                            opEnd    = 1'b1;
                        end
                    end
                end
            end
            OP_WIPE: begin
                dWe     = !opPgm_q && !holeAddr;
                dWrData = `NVM_ERASED_BYTE;
                pWe     = opPgm_q;
                pWrAddr = {pgmAddr[10:5], cnt_q};
                pWrData = `NVM_ERASED_WORD;
                if (cnt_q == (opPgm_q ? `NVM_ROW_LAST : 5'h00)) begin
                    st_d  = OP_WAIT_ERASE;
                    tmr_d = tmrLoad;
                    cnt_d = 5'h00;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            OP_WAIT_ERASE: begin
                if (tmr_q == '0) begin
                    if (opPgm_q) begin
                        st_d     = OP_IDLE;
                        commit_d = 1'b0;
                        opEnd    = 1'b1;
                    end else begin
                        st_d = OP_FILL;
                    end
                end else begin
                    tmr_d = tmr_q - TW'(1);
                end
            end
            OP_FILL: begin
                dWe = !opPgm_q && !holeAddr;
                pWe = opPgm_q;
                if (cnt_q == (opPgm_q ? `NVM_BLK_LAST : 5'h00)) begin
                    st_d  = OP_WAIT_PROG;
                    tmr_d = tmrLoad;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            OP_WAIT_PROG: begin
                if (tmr_q == '0) begin
                    st_d     = OP_IDLE;
                    commit_d = 1'b0;
                    opEnd    = 1'b1;
                end else begin
                    tmr_d = tmr_q - TW'(1);
                end
            end
        endcase
        // Pin or watchdog reset ends the operation; permit is left alone
        if (softRst) begin
            st_d     = OP_IDLE;
            commit_d = 1'b0;
            opEnd    = 1'b0;
        end
    end

    // ********************************************
    // Software-visible registers
    // ********************************************
    // Data and address are frozen while the sequencer uses them
    always_comb begin
        dataLo_d    = dataLo_q;
        dataHi_d    = dataHi_q;
        addrLo_d    = addrLo_q;
        addrHi_d    = addrHi_q;
        space_d     = space_q;
        rowErase_d  = rowErase_q;
        permit_d    = permit_q;
        abort_d     = abort_q;
        irqEn_d     = irqEn_q;
        doneFlag_d  = doneFlag_q;
        fetch_d     = fetchStart;
        fetchPgm_d  = sfrReq.wdata[`NVM_BIT_SPACE];
        fetchHole_d = holeAddr;
        if (sfrReq.we && !busy) begin
            unique case (sfrReq.addr)
                `NVM_OFS_DATA_LO: dataLo_d = sfrReq.wdata;
                `NVM_OFS_DATA_HI: dataHi_d = sfrReq.wdata[5:0];
                `NVM_OFS_ADDR_LO: addrLo_d = sfrReq.wdata;
                `NVM_OFS_ADDR_HI: addrHi_d = sfrReq.wdata[4:0];
                default: ;
            endcase
        end
        if (wrCtrl) begin
            permit_d = sfrReq.wdata[`NVM_BIT_PERMIT];
            abort_d  = sfrReq.wdata[`NVM_BIT_ABORT];
            if (!busy) begin
                space_d    = sfrReq.wdata[`NVM_BIT_SPACE];
                rowErase_d = sfrReq.wdata[`NVM_BIT_ERASE];
            end
        end
        if (sfrReq.we && sfrReq.addr == `NVM_OFS_IRQ_EN) begin
            irqEn_d = sfrReq.wdata[`NVM_BIT_DONE];
        end
        if (sfrReq.we && sfrReq.addr == `NVM_OFS_IRQ_FLAG) begin
            doneFlag_d = sfrReq.wdata[`NVM_BIT_DONE];
        end
        // Captured read data; internal reads ignore code protection
        if (fetch_q) begin
            dataLo_d = fetchPgm_q ? pRd[7:0] : (fetchHole_q ? 8'h00 : dRd);
            dataHi_d = fetchPgm_q ? pRd[13:8] : dataHi_q;
        end
        // Hardware sets win over a same-cycle software clear
        if (opEnd) begin
            doneFlag_d = 1'b1;
        end
        if (softRst) begin
            space_d = 1'b0;
            fetch_d = 1'b0;
            if (busy) begin
                abort_d = 1'b1;
            end
        end
    end

    // Register read port answers one cycle after the strobe
    // Data registers give their next value, so a fetch shows in the very next read
    always_comb begin
        rdData_d = rdData_q;
        if (sfrReq.re) begin
            unique case (sfrReq.addr)
                `NVM_OFS_CTRL:     rdData_d = {space_q, 2'b00, rowErase_q, abort_q,
                                               permit_q, commit_q, fetch_q};
                `NVM_OFS_DATA_LO:  rdData_d = dataLo_d;
                `NVM_OFS_DATA_HI:  rdData_d = {2'b00, dataHi_d};
                `NVM_OFS_ADDR_LO:  rdData_d = addrLo_q;
                `NVM_OFS_ADDR_HI:  rdData_d = {3'b000, addrHi_q};
                `NVM_OFS_IRQ_EN:   rdData_d = {3'b000, irqEn_q, 4'h0};
                `NVM_OFS_IRQ_FLAG: rdData_d = {3'b000, doneFlag_q, 4'h0};
                default:           rdData_d = 8'h00;
            endcase
        end
    end

    // ********************************************
    // State registers
    // ********************************************
    // Data and address hold across pin and watchdog resets
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dataLo_q <= 8'h00;  dataHi_q <= 6'h00;  addrLo_q <= 8'h00;  addrHi_q <= 5'h00;
            space_q <= 1'b0;  rowErase_q <= 1'b0;  abort_q <= 1'b0;  permit_q <= 1'b0;
            commit_q <= 1'b0;  fetch_q <= 1'b0;  doneFlag_q <= 1'b0;  irqEn_q <= 1'b0;
            opPgm_q <= 1'b0;  fetchPgm_q <= 1'b0;  fetchHole_q <= 1'b0;
            cnt_q <= 5'h00;  tmr_q <= '0;  rdData_q <= 8'h00;
            ul_q <= UL_IDLE;  st_q <= OP_IDLE;
            for (int i = 0; i < 4; i++) begin
                blk_q[i] <= 14'h0000;
            end
        end else begin
            dataLo_q <= dataLo_d;  dataHi_q <= dataHi_d;  addrLo_q <= addrLo_d;
            addrHi_q <= addrHi_d;  space_q <= space_d;  rowErase_q <= rowErase_d;
            abort_q <= abort_d;  permit_q <= permit_d;  commit_q <= commit_d;
            fetch_q <= fetch_d;  doneFlag_q <= doneFlag_d;  irqEn_q <= irqEn_d;
            opPgm_q <= opPgm_d;  fetchPgm_q <= fetchPgm_d;  fetchHole_q <= fetchHole_d;
            cnt_q <= cnt_d;  tmr_q <= tmr_d;  rdData_q <= rdData_d;
            ul_q <= ul_d;  st_q <= st_d;  blk_q <= blk_d;
        end
    end

    // ********************************************
    // Arrays and outputs
    // ********************************************
    nvm_store #(.WIDTH(8), .AW(`NVM_DATA_AW)) dataStore (
        .sys_clk (sys_clk),
        .rst     (rst),
        .update_permit    (dWe),
        .wrAddr  (addrLo_q),
        .wrData  (dWrData),
        .rdEn    (fetchStart),
        .rdAddr  (addrLo_q),
        .rdData  (dRd)
    );

    nvm_store #(.WIDTH(14), .AW(`NVM_PGM_AW)) pgmStore (
        .sys_clk (sys_clk),
        .rst     (rst),
        .update_permit    (pWe),
        .wrAddr  (pWrAddr),
        .wrData  (pWrData),
        .rdEn    (fetchStart),
        .rdAddr  (pgmAddr),
        .rdData  (pRd)
    );

    assign sfrRdData = rdData_q;
    assign nvmIrqReq = doneFlag_q && irqEn_q;
    assign pumpOn    = busy && (opPgm_q || !holeAddr);
    assign nvmBusy   = busy;

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_hole_reads_zero: assert property (fetch_q && !fetchPgm_q && fetchHole_q |=> dataLo_q == 8'h00)
        else $error("unimplemented data address read non-zero");
    a_pump_hole_off: assert property (busy && !opPgm_q && holeAddr |-> !pumpOn && !dWe)
        else $error("pump on for unimplemented address");
    a_erase_then_prog: assert property ($rose(st_q == OP_FILL) && !opPgm_q |-> $past(st_q) == OP_WAIT_ERASE)
        else $error("data program without erase");
    a_timer_expiry: assert property ($fell(commit_q) && !$past(softRst) |-> $past(tmr_q) == '0)
        else $error("write ended before timer expired");
    a_space_frozen: assert property (busy && !softRst |=> $stable(space_q))
        else $error("space select changed during write");
    a_commit_held: assert property (commit_q && !opEnd && !softRst |=> commit_q)
        else $error("commit trigger cleared early");
    a_permit_sw_only: assert property (!wrCtrl |=> $stable(permit_q))
        else $error("update permit changed by hardware");
    a_abort_on_reset: assert property (softRst && busy |=> abort_q && st_q == OP_IDLE)
        else $error("interrupted write did not flag abort");
    a_done_on_end: assert property (opEnd |=> doneFlag_q && !commit_q)
        else $error("done flag not set at write end");
    a_key_reads_zero: assert property (sfrReq.re && sfrReq.addr == `NVM_OFS_KEY |=> sfrRdData == 8'h00)
        else $error("key port read non-zero");
    a_unlock_needed: assert property ($rose(commit_q) |-> $past(ul_q) == UL_ARMED && $past(permit_q))
        else $error("commit without unlock or permit");
    a_irq_gate: assert property ($rose(nvmIrqReq) |-> $past(opEnd) || $past(sfrReq.we))
        else $error("irq request rose with no cause");

    c_data_write: cover property (st_q == OP_WAIT_PROG && !opPgm_q && opEnd ##1 doneFlag_q);
    c_row_erase: cover property (st_q == OP_WIPE && opPgm_q && cnt_q == `NVM_ROW_LAST);
    c_fetch: cover property (fetchStart ##1 fetch_q);
    c_abort: cover property (softRst && busy);

endmodule
`default_nettype wire

// ### core/nvm_map.svh
// Register offsets, field positions, key and erased values, sizes and timing for the nonvolatile access block
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// ********************************************
// Special register offsets
// ********************************************
`define NVM_OFS_CTRL     9'h18C
`define NVM_OFS_KEY      9'h18D
`define NVM_OFS_DATA_LO  9'h10C
`define NVM_OFS_ADDR_LO  9'h10D
`define NVM_OFS_DATA_HI  9'h10E
`define NVM_OFS_ADDR_HI  9'h10F
`define NVM_OFS_IRQ_EN   9'h08D
`define NVM_OFS_IRQ_FLAG 9'h00D

// ********************************************
// Field positions
// ********************************************
`define NVM_BIT_SPACE    7
`define NVM_BIT_ERASE    4
`define NVM_BIT_ABORT    3
`define NVM_BIT_PERMIT   2
`define NVM_BIT_COMMIT   1
`define NVM_BIT_FETCH    0
`define NVM_BIT_DONE     4

// ********************************************
// Values, sizes and timing
// ********************************************
`define NVM_KEY_FIRST    8'h55
`define NVM_KEY_SECOND   8'hAA
`define NVM_ERASED_BYTE  8'hFF
`define NVM_ERASED_WORD  14'h3FFF
`define NVM_DATA_AW      8
`define NVM_PGM_AW       11
`define NVM_ROW_LAST     5'h1F
`define NVM_BLK_LAST     5'h03
`define NVM_CLK_NS       50
`define NVM_WRITE_NS     2000000
`define NVM_WRITE_CYCLES ((`NVM_WRITE_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)

`endif

// ### core/nvm_pkg.sv
// Types shared by the nonvolatile access block
package nvm_pkg;

    // One access from the core to the special registers
    typedef struct packed {
        logic       we;
        logic       re;
        logic [8:0] addr;
        logic [7:0] wdata;
    } nvm_sfr_req_t;

    typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_ARMED} nvm_unlock_t;

    typedef enum logic [2:0] {OP_IDLE, OP_WIPE, OP_WAIT_ERASE, OP_FILL, OP_WAIT_PROG} nvm_op_t;

endpackage

// ### core/nvm_store.sv
// Simple dual-port array with registered read data
`timescale 1ns/1ps
`default_nettype none
module nvm_store
    import nvm_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int AW    = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             update_permit,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             rdEn,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [0:(1<<AW)-1];
    logic [WIDTH-1:0] rdData_q;
    logic [WIDTH-1:0] rdData_d;

    // Array contents survive reset, as a real cell would
    always_ff @(posedge sys_clk) begin
        if (update_permit) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Read data only moves when a read is asked for
    always_comb begin
        rdData_d = rdEn ? mem[rdAddr] : rdData_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign rdData = rdData_q;

endmodule
`default_nettype wire

// ### bench/nvm_core_model.sv
// Processor-side model that issues special register accesses
`timescale 1ns/1ps
`default_nettype none
`include "nvm_map.svh"
module nvm_core_model
    import nvm_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic   [7:0] sfrRdData,
    output var nvm_sfr_req_t  sfrReq
);
    initial sfrReq = '0;

    // One write, launched off the falling edge and held across one rising edge
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfrReq = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        // Released bus shows inverted values so no stale address looks valid
        sfrReq = '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // One read; data is taken two cycles after the falling edge that raises the strobe
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfrReq = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        sfrReq = '{we: 1'b0, re: 1'b0, addr: ~a, wdata: 8'hFF};
        @(negedge sys_clk);
        d = sfrRdData;
    endtask

    // Keys then commit, nothing in between; caller keeps interrupts masked
    task automatic unlock_commit(input logic [7:0] ctl);
        wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
        wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
        wr(`NVM_OFS_CTRL, ctl);
    endtask
endmodule
`default_nettype wire

// ### bench/nvm_access_ctrl_tb.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
`default_nettype none
`include "nvm_map.svh"
module nvm_access_ctrl_tb;
    import nvm_pkg::*;
    // Short write time keeps the run brief
    localparam int WC = 8;
    logic         sys_clk;
    logic         rst;
    logic         extRstReq;
    logic         wdtRstReq;
    nvm_sfr_req_t sfrReq;
    logic   [7:0] sfrRdData;
    logic   [7:0] rdv;
    logic         nvmIrqReq;
    logic         pumpOn;
    logic         nvmBusy;
    int           err_total;
    int           n_compared;
    int           pumpHits;

    nvm_access_ctrl #(.SMALL_PART(1'b1), .WRITE_CYCLES(WC)) uut (
        .sys_clk(sys_clk), .rst(rst), .sfrReq(sfrReq), .extRstReq(extRstReq),
        .wdtRstReq(wdtRstReq), .sfrRdData(sfrRdData), .nvmIrqReq(nvmIrqReq),
        .pumpOn(pumpOn), .nvmBusy(nvmBusy));

    nvm_core_model core (.sys_clk(sys_clk), .sfrRdData(sfrRdData), .sfrReq(sfrReq));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Counts pump-on cycles at the falling edge, where the outputs have settled
    always @(negedge sys_clk) begin
        if (pumpOn === 1'b1) pumpHits++;
    end

    // ********************************************
    // Checking helpers
    // ********************************************
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [8:0] a, input logic [7:0] exp);
        core.rd(a, rdv);
        check(rdv, exp);
    endtask

    // Bounded wait for the sequencer to go idle
    task automatic wait_idle();
        int n;
        n = 0;
        while (nvmBusy !== 1'b0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 200) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        rst = 1'b1;
        extRstReq = 1'b0;
        wdtRstReq = 1'b0;
        err_total = 0;
        n_compared = 0;
        pumpHits = 0;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        rdchk(`NVM_OFS_CTRL, 8'h00);
        rdchk(`NVM_OFS_KEY, 8'h00);
        rdchk(9'h1FF, 8'h00);
        // Byte write; space change and permit clear attempted mid-write
        core.wr(`NVM_OFS_ADDR_LO, 8'h05);
        core.wr(`NVM_OFS_DATA_LO, 8'hA5);
        core.wr(`NVM_OFS_CTRL, 8'h04);
        pumpHits = 0;
        core.unlock_commit(8'h06);
        check({7'h00, nvmBusy}, 8'h01);
        rdchk(`NVM_OFS_CTRL, 8'h06);
        core.wr(`NVM_OFS_CTRL, 8'h80);
        wait_idle();
        check((pumpHits > 2 * WC) ? 8'h01 : 8'h00, 8'h01);
        rdchk(`NVM_OFS_CTRL, 8'h00);
        rdchk(`NVM_OFS_IRQ_FLAG, 8'h10);
        check({7'h00, nvmIrqReq}, 8'h00);
        core.wr(`NVM_OFS_IRQ_EN, 8'h10);
        check({7'h00, nvmIrqReq}, 8'h01);
        core.wr(`NVM_OFS_IRQ_FLAG, 8'h00);
        check({7'h00, nvmIrqReq}, 8'h00);
        core.wr(`NVM_OFS_CTRL, 8'h01);
        rdchk(`NVM_OFS_DATA_LO, 8'hA5);
        rdchk(`NVM_OFS_DATA_LO, 8'hA5);
        // Commit refused without permit, and with a broken key sequence
        core.wr(`NVM_OFS_CTRL, 8'h00);
        core.unlock_commit(8'h02);
        check({7'h00, nvmBusy}, 8'h00);
        core.wr(`NVM_OFS_CTRL, 8'h04);
        core.wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
        core.wr(`NVM_OFS_ADDR_LO, 8'h07);
        core.wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
        core.wr(`NVM_OFS_CTRL, 8'h06);
        check({7'h00, nvmBusy}, 8'h00);
        // Pin reset, then watchdog reset, in mid-write
        core.wr(`NVM_OFS_DATA_LO, 8'h3C);
        for (int s = 0; s < 2; s++) begin
            core.wr(`NVM_OFS_CTRL, 8'h04);
            core.unlock_commit(8'h06);
            repeat (3) @(negedge sys_clk);
            extRstReq = (s == 0);
            wdtRstReq = (s == 1);
            @(negedge sys_clk);
            extRstReq = 1'b0;
            wdtRstReq = 1'b0;
            check({7'h00, nvmBusy}, 8'h00);
            rdchk(`NVM_OFS_CTRL, 8'h0C);
            rdchk(`NVM_OFS_ADDR_LO, 8'h07);
            rdchk(`NVM_OFS_DATA_LO, 8'h3C);
        end
        // Upper data half is missing on the small part
        core.wr(`NVM_OFS_CTRL, 8'h04);
        core.wr(`NVM_OFS_ADDR_LO, 8'h85);
        core.wr(`NVM_OFS_DATA_LO, 8'h5A);
        pumpHits = 0;
        core.unlock_commit(8'h06);
        wait_idle();
        check(pumpHits[7:0], 8'h00);
        rdchk(`NVM_OFS_IRQ_FLAG, 8'h10);
        core.wr(`NVM_OFS_CTRL, 8'h05);
        rdchk(`NVM_OFS_DATA_LO, 8'h00);
        rdchk(`NVM_OFS_CTRL, 8'h04);
        // Program space: row erase, one 4-word block, wrapped read back
        core.wr(`NVM_OFS_ADDR_LO, 8'h00);
        core.wr(`NVM_OFS_DATA_HI, 8'h2A);
        core.wr(`NVM_OFS_CTRL, 8'h94);
        pumpHits = 0;
        core.unlock_commit(8'h96);
        wait_idle();
        check(pumpHits[7:0], 8'h28);
        core.wr(`NVM_OFS_CTRL, 8'h84);
        for (int w = 0; w < 4; w++) begin
            core.wr(`NVM_OFS_ADDR_LO, 8'(w));
            core.wr(`NVM_OFS_DATA_LO, 8'h10 + 8'(w));
            core.unlock_commit(8'h86);
        end
        wait_idle();
        core.wr(`NVM_OFS_ADDR_HI, 8'h04);
        for (int w = 2; w < 6; w += 3) begin
            core.wr(`NVM_OFS_ADDR_LO, 8'(w));
            core.wr(`NVM_OFS_CTRL, 8'h81);
            rdchk(`NVM_OFS_DATA_LO, (w == 2) ? 8'h12 : 8'hFF);
            rdchk(`NVM_OFS_DATA_HI, (w == 2) ? 8'h2A : 8'h3F);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
